// File: core/csbec_top.v
/*
 secondary cache and system bus error checking: data array parity and
 re-read, tag correction, bus parity and ECC, fault flags, error pulses.
 assumes the cache array honours the re-read request and that bus pins
 are asynchronous to ref_clk; the system clock is an enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csbec_regs.vh"
module csbec_top #(
	parameter SYS_DIV = `CSBEC_SYS_DIV,
	parameter COR_LAT = `CSBEC_COR_LAT,
	parameter BEATS = `CSBEC_BLOCK_BEATS,
	parameter IW = `CSBEC_IDX_W
) (
	input wire ref_clk,
	input wire reset,
	input wire l2_correction_enable,
	input wire l2_rd_valid,
	input wire [`CSBEC_L2_DW-1:0] l2_rd_data,
	input wire [`CSBEC_L2_CW:0] l2_data_check_bits_in,
	input wire [IW-1:0] l2_rd_index,
	output reg l2_reread_req_q,
	output reg l2_out_valid_q,
	output reg [`CSBEC_L2_DW-1:0] l2_out_data_q,
	input wire [`CSBEC_L2_DW-1:0] l2_wr_data,
	output wire [`CSBEC_L2_CW:0] l2_data_check_bits_out,
	input wire l2_tag_rd_valid,
	input wire [`CSBEC_TAG_DW-1:0] l2_tag_rd,
	input wire [`CSBEC_TAG_CW-1:0] l2_label_check_bits_in,
	input wire [IW-1:0] l2_tag_index,
	output wire [`CSBEC_TAG_DW-1:0] l2_tag_fixed,
	input wire [`CSBEC_TAG_DW-1:0] l2_tag_wr,
	output wire [`CSBEC_TAG_CW-1:0] l2_label_check_bits_out,
	input wire master_state,
	input wire mst_valid,
	input wire [`CSBEC_CMD_W-1:0] mst_cmd,
	input wire [`CSBEC_AD_W-1:0] mst_ad,
	output reg bus_drive_oe_q,
	output reg bus_valid_strobe_n_o_q,
	output reg [`CSBEC_CMD_W-1:0] command_bus_o_q,
	output reg command_parity_o_q,
	output reg [`CSBEC_AD_W-1:0] addr_data_bus_o_q,
	output reg [`CSBEC_AD_CW-1:0] addr_data_check_bits_o_q,
	input wire bus_valid_strobe_n,
	input wire [`CSBEC_CMD_W-1:0] command_bus,
	input wire command_parity,
	input wire [`CSBEC_AD_W-1:0] addr_data_bus,
	input wire [`CSBEC_AD_CW-1:0] addr_data_check_bits,
	input wire own_read_data,
	output reg rx_valid_q,
	output reg [`CSBEC_CMD_W-1:0] rx_cmd_q,
	output reg [`CSBEC_AD_W-1:0] rx_ad_q,
	output reg rx_unc_q,
	input wire cache_fault_clear,
	output reg cache_err_exc_q,
	output reg data_fault_flag_q,
	output reg label_fault_flag_q,
	output reg cmd_parity_flag_q,
	output reg addr_phase_flag_q,
	output reg [IW-1:0] l2_set_position_field_q,
	output reg perf_count0_event_q,
	output wire corrected_error_pulse_n,
	output wire fatal_error_pulse_n
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RRD = 2'b10;
	localparam DIVW = 8;
	localparam [DIVW-1:0] DIV_LAST = SYS_DIV[DIVW-1:0] - 8'h01;
	localparam [7:0] BEAT_LAST = BEATS[7:0] - 8'h01;

	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [7:0] beat_q;
	reg [DIVW-1:0] div_q;
	reg sys_en;
	reg [`CSBEC_L2_DW-1:0] pipe_data_q [0:COR_LAT-1];
	reg [IW-1:0] pipe_idx_q [0:COR_LAT-1];
	reg [COR_LAT-1:0] pipe_vld_q;
	reg [COR_LAT-1:0] pipe_unc_q;
	reg [COR_LAT-1:0] pipe_cor_q;
	integer k;

	wire [`CSBEC_L2_CW-1:0] d_gen_unused;
	wire [`CSBEC_L2_DW-1:0] d_fix;
	wire d_single;
	wire d_double;
	wire [`CSBEC_L2_DW-1:0] d_wr_fix_unused;
	wire t_single;
	wire t_double;
	wire [`CSBEC_TAG_CW-1:0] t_gen_unused;
	wire [`CSBEC_AD_CW-1:0] a_gen_unused;
	wire [`CSBEC_AD_W-1:0] a_fix;
	wire a_single;
	wire a_double;

	reg vn_s1_q;
	reg vn_s2_q;
	reg par_s1_q;
	reg par_s2_q;
	reg [`CSBEC_CMD_W-1:0] cmd_s1_q;
	reg [`CSBEC_CMD_W-1:0] cmd_s2_q;
	reg [`CSBEC_AD_W-1:0] ad_s1_q;
	reg [`CSBEC_AD_W-1:0] ad_s2_q;
	reg [`CSBEC_AD_CW-1:0] chk_s1_q;
	reg [`CSBEC_AD_CW-1:0] chk_s2_q;

	// system interface period as a one-cycle enable
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			div_q <= 8'h00;
			sys_en <= 1'b0;
		end
		else
		begin
			sys_en <= (div_q == DIV_LAST);
			div_q <= (div_q == DIV_LAST) ? 8'h00 : div_q + 8'h01;
		end
	end

	// data array corrector and write-side generator
	csbec_secded #(.DW(`CSBEC_L2_DW), .CW(`CSBEC_L2_CW)) u_drd (
		.data_in(l2_rd_data),
		.check_in(l2_data_check_bits_in[`CSBEC_L2_CW-1:0]),
		.check_gen(d_gen_unused),
		.data_fix(d_fix),
		.single_err(d_single),
		.double_err(d_double)
	);
	csbec_secded #(.DW(`CSBEC_L2_DW), .CW(`CSBEC_L2_CW)) u_dwr (
		.data_in(l2_wr_data),
		.check_in(9'h000),
		.check_gen(l2_data_check_bits_out[`CSBEC_L2_CW-1:0]),
		.data_fix(d_wr_fix_unused),
		.single_err(),
		.double_err()
	);
	assign l2_data_check_bits_out[`CSBEC_L2_PAR_BIT] = ^l2_wr_data;

	wire in_rrd = st_q[1];
	// corrector only when enabled or re-reading
	wire use_cor = l2_correction_enable | in_rrd;
	wire par_bad = ^{l2_rd_data, l2_data_check_bits_in[`CSBEC_L2_PAR_BIT]};
	wire par_evt = l2_rd_valid & ~use_cor & par_bad;
	wire last_beat = in_rrd & l2_rd_valid & (beat_q == BEAT_LAST);

	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (par_evt)
					st_d = ST_RRD;
			ST_RRD:
				if (last_beat)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// count block beats of the re-read
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			st_q <= ST_IDLE;
			beat_q <= 8'h00;
			l2_reread_req_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			l2_reread_req_q <= st_d[1];
			if (!in_rrd || last_beat)
				beat_q <= 8'h00;
			else if (l2_rd_valid)
				beat_q <= beat_q + 8'h01;
		end
	end

	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			pipe_vld_q <= {COR_LAT{1'b0}};
			pipe_unc_q <= {COR_LAT{1'b0}};
			pipe_cor_q <= {COR_LAT{1'b0}};
		end
		else
		begin
			pipe_vld_q <= {pipe_vld_q[COR_LAT-2:0], l2_rd_valid & use_cor};
			pipe_cor_q <= {pipe_cor_q[COR_LAT-2:0], l2_rd_valid & use_cor & d_single};
			pipe_unc_q <= {pipe_unc_q[COR_LAT-2:0], l2_rd_valid & use_cor & d_double};
		end
		pipe_data_q[0] <= d_fix;
		pipe_idx_q[0] <= l2_rd_index;
		for (k = 1; k < COR_LAT; k = k + 1)
		begin
			pipe_data_q[k] <= pipe_data_q[k-1];
			pipe_idx_q[k] <= pipe_idx_q[k-1];
		end
	end

	// output stage; a bad-parity beat is dropped in favour of the re-read
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			l2_out_valid_q <= 1'b0;
			l2_out_data_q <= {`CSBEC_L2_DW{1'b0}};
		end
		else if (pipe_vld_q[COR_LAT-1])
		begin
			l2_out_valid_q <= 1'b1;
			l2_out_data_q <= pipe_data_q[COR_LAT-1];
		end
		else
		begin
			l2_out_valid_q <= l2_rd_valid & ~use_cor & ~par_bad;
			l2_out_data_q <= l2_rd_data;
		end
	end

	wire data_cor_evt = pipe_cor_q[COR_LAT-1];
	wire data_unc_evt = pipe_unc_q[COR_LAT-1];

	// counter zero event per corrected data error
	always @(posedge ref_clk)
	begin
		if (reset)
			perf_count0_event_q <= 1'b0;
		else
			perf_count0_event_q <= data_cor_evt;
	end

	csbec_secded #(.DW(`CSBEC_TAG_DW), .CW(`CSBEC_TAG_CW)) u_trd (
		.data_in(l2_tag_rd),
		.check_in(l2_label_check_bits_in),
		.check_gen(t_gen_unused),
		.data_fix(l2_tag_fixed),
		.single_err(t_single),
		.double_err(t_double)
	);
	csbec_secded #(.DW(`CSBEC_TAG_DW), .CW(`CSBEC_TAG_CW)) u_twr (
		.data_in(l2_tag_wr),
		.check_in(7'h00),
		.check_gen(l2_label_check_bits_out),
		.data_fix(),
		.single_err(),
		.double_err()
	);
	wire tag_cor_evt = l2_tag_rd_valid & t_single;
	wire tag_unc_evt = l2_tag_rd_valid & t_double;

	// two-flop synchronisers on every bus pin
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			vn_s1_q <= 1'b1;
			vn_s2_q <= 1'b1;
		end
		else
		begin
			vn_s1_q <= bus_valid_strobe_n;
			vn_s2_q <= vn_s1_q;
		end
		par_s1_q <= command_parity;
		par_s2_q <= par_s1_q;
		cmd_s1_q <= command_bus;
		cmd_s2_q <= cmd_s1_q;
		ad_s1_q <= addr_data_bus;
		ad_s2_q <= ad_s1_q;
		chk_s1_q <= addr_data_check_bits;
		chk_s2_q <= chk_s1_q;
	end

	// eight-bit check on the address/data bus
	csbec_secded #(.DW(`CSBEC_AD_W), .CW(`CSBEC_AD_CW)) u_adrx (
		.data_in(ad_s2_q),
		.check_in(chk_s2_q),
		.check_gen(a_gen_unused),
		.data_fix(a_fix),
		.single_err(a_single),
		.double_err(a_double)
	);
	wire [`CSBEC_AD_CW-1:0] tx_chk;
	csbec_secded #(.DW(`CSBEC_AD_W), .CW(`CSBEC_AD_CW)) u_adtx (
		.data_in(mst_ad),
		.check_in(8'h00),
		.check_gen(tx_chk),
		.data_fix(),
		.single_err(),
		.double_err()
	);

	wire rx_take = sys_en & ~master_state & ~vn_s2_q;
	wire cmd_err_evt = rx_take & ~(^{cmd_s2_q, par_s2_q});
	// ECC only when command bit enables
	wire ad_chk = rx_take & cmd_s2_q[`CSBEC_CMD_CHK_EN_BIT] & ~cmd_err_evt;
	wire addr_cyc = cmd_s2_q[`CSBEC_CMD_ADDR_BIT];
	// correctable address or own-read data cycle
	wire ad_cor_evt = ad_chk & a_single & (addr_cyc | own_read_data);
	// fatal error in an address cycle
	wire ad_unc_evt = ad_chk & a_double & addr_cyc;
	wire ad_fix_use = ad_chk & a_single & (addr_cyc | own_read_data);

	// drop the cycle on command parity or fatal address errors
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			rx_valid_q <= 1'b0;
			rx_cmd_q <= 12'h000;
			rx_ad_q <= 64'h0000000000000000;
			rx_unc_q <= 1'b0;
		end
		else if (sys_en)
		begin
			rx_valid_q <= rx_take & ~cmd_err_evt & ~ad_unc_evt;
			rx_cmd_q <= cmd_s2_q;
			rx_ad_q <= ad_fix_use ? a_fix : ad_s2_q;
			rx_unc_q <= ad_chk & a_double & ~addr_cyc & own_read_data;
		end
	end

	// master drive with odd command parity
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			bus_drive_oe_q <= 1'b0;
			bus_valid_strobe_n_o_q <= 1'b1;
			command_bus_o_q <= 12'h000;
			command_parity_o_q <= 1'b1;
			addr_data_bus_o_q <= 64'h0000000000000000;
			addr_data_check_bits_o_q <= 8'h00;
		end
		else if (sys_en)
		begin
			bus_drive_oe_q <= master_state;
			bus_valid_strobe_n_o_q <= ~(master_state & mst_valid);
			command_bus_o_q <= mst_cmd;
			command_parity_o_q <= ~(^mst_cmd);
			addr_data_bus_o_q <= mst_ad;
			addr_data_check_bits_o_q <= tx_chk;
		end
	end

	// exception, fault flags and index
	// set beats clear so no fault is lost
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			cache_err_exc_q <= 1'b0;
			data_fault_flag_q <= 1'b0;
			label_fault_flag_q <= 1'b0;
			cmd_parity_flag_q <= 1'b0;
			addr_phase_flag_q <= 1'b0;
			l2_set_position_field_q <= {IW{1'b0}};
		end
		else
		begin
			cache_err_exc_q <= data_unc_evt | tag_unc_evt | cmd_err_evt | ad_unc_evt;
			data_fault_flag_q <= data_unc_evt | (data_fault_flag_q & ~cache_fault_clear);
			label_fault_flag_q <= tag_unc_evt | (label_fault_flag_q & ~cache_fault_clear);
			cmd_parity_flag_q <= cmd_err_evt | (cmd_parity_flag_q & ~cache_fault_clear);
			addr_phase_flag_q <= ad_unc_evt | (addr_phase_flag_q & ~cache_fault_clear);
			if (tag_unc_evt)
				l2_set_position_field_q <= l2_tag_index;
			else if (data_unc_evt)
				l2_set_position_field_q <= pipe_idx_q[COR_LAT-1];
		end
	end

	// corrected pulse for data, tag and bus
	csbec_pulse #(.NSRC(3)) u_cor_pulse (
		.ref_clk(ref_clk),
		.reset(reset),
		.sys_en(sys_en),
		.event_in({data_cor_evt, tag_cor_evt, ad_cor_evt}),
		.pulse_n_q(corrected_error_pulse_n)
	);
	// fatal pulse for tag, command and address
	csbec_pulse #(.NSRC(3)) u_unc_pulse (
		.ref_clk(ref_clk),
		.reset(reset),
		.sys_en(sys_en),
		.event_in({tag_unc_evt, cmd_err_evt, ad_unc_evt}),
		.pulse_n_q(fatal_error_pulse_n)
	);
endmodule // csbec_top
`default_nettype wire

// File: common/csbec_regs.vh
/*
 constants of the cache and system bus error checker: widths, field
 positions and timing counts. assumes inclusion by every design file that uses them.
*/
// Function
// - correction-enable low selects noncorrection data reads
// - noncorrection reads check even parity on bit 9
// - parity error re-reads whole block through corrector
// - corrected data error pulses corrected output once
// - uncorrectable data error: exception, data flag, index
// - correctable data errors count on counter zero
// - tag holds 26 bits with 7-bit check
// - tag read corrected in-line, corrected pulse
// - tag fatal error: exception, flag, fatal pulse
// - tag writes drive generated 7-bit check
// - command, state, response odd parity; data ECC; code has no state or response bus, only command parity
// - master command drive carries odd parity
// - slave command parity checked, agent supplies it
// - command parity error ignores cycle, flags, pulses
// - master address/data drive carries 8-bit check
// - slave checks ECC only when command bit enables
// - correctable bus error fixed in-line, pulsed; code does so in address and own-read data cycles only
// - data writes drive ECC and even parity
// - correction mode adds two cycles refill latency
// - address cycle fatal error ignores, flags, pulses
`ifndef CSBEC_REGS_VH
`define CSBEC_REGS_VH
`define CSBEC_REF_CLK_MHZ 200
`define CSBEC_SYS_DIV 4
`define CSBEC_COR_LAT 2
`define CSBEC_BLOCK_BEATS 8
`define CSBEC_L2_DW 128
`define CSBEC_L2_CW 9
`define CSBEC_L2_PAR_BIT 9
`define CSBEC_TAG_DW 26
`define CSBEC_TAG_CW 7
`define CSBEC_CMD_W 12
`define CSBEC_AD_W 64
`define CSBEC_AD_CW 8
`define CSBEC_CMD_CHK_EN_BIT 0
`define CSBEC_CMD_ADDR_BIT 11
`define CSBEC_IDX_W 16
`define CSBEC_PEND_W 4
`endif

// File: core/csbec_secded.v
/*
 single-error-correct double-error-detect code: generator, syndrome and
 corrector. assumes data and check arrive together on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module csbec_secded #(
	parameter DW = 64,
	parameter CW = 8
) (
	input wire [DW-1:0] data_in,
	input wire [CW-1:0] check_in,
	output wire [CW-1:0] check_gen,
	output wire [DW-1:0] data_fix,
	output wire single_err,
	output wire double_err
);
	wire [CW-1:0] syn;

	// count of ones in a candidate column
	function integer ones;
		input integer v;
		integer b;
		begin
			ones = 0;
			for (b = 0; b < CW; b = b + 1)
				ones = ones + ((v >> b) & 1);
		end
	endfunction

	// column of data bit idx: the idx-th odd word of weight three or more
	function [CW-1:0] col;
		input integer idx;
		integer v;
		integer n;
		begin
			col = {CW{1'b0}};
			n = 0;
			for (v = 0; v < (1 << CW); v = v + 1)
				if ((ones(v) % 2 == 1) && (ones(v) >= 3))
				begin
					if (n == idx)
						col = v[CW-1:0];
					n = n + 1;
				end
		end
	endfunction

	// mask of data bits feeding check bit j
	function [DW-1:0] row;
		input integer j;
		integer i;
		reg [CW-1:0] c;
		begin
			row = {DW{1'b0}};
			for (i = 0; i < DW; i = i + 1)
			begin
				c = col(i);
				row[i] = c[j];
			end
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < CW; g = g + 1)
		begin : g_chk
			localparam [DW-1:0] MASK = row(g);
			assign check_gen[g] = ^(data_in & MASK);
		end
		for (g = 0; g < DW; g = g + 1)
		begin : g_fix
			localparam [CW-1:0] COL = col(g);
			assign data_fix[g] = data_in[g] ^ (syn == COL);
		end
	endgenerate

	// odd syndrome weight is one flipped bit, even nonzero is two
	assign syn = check_gen ^ check_in;
	assign single_err = ^syn;
	assign double_err = (|syn) & ~(^syn);
endmodule // csbec_secded
`default_nettype wire

// File: core/csbec_pulse.v
/*
 active-low error pulse of one system interface period per event, up to 15 pending.
 assumes sys_en is a one-cycle enable once per system period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csbec_regs.vh"
module csbec_pulse #(
	parameter NSRC = 3
) (
	input wire ref_clk,
	input wire reset,
	input wire sys_en,
	input wire [NSRC-1:0] event_in,
	output reg pulse_n_q
);
	reg [`CSBEC_PEND_W-1:0] pend_q;
	reg [`CSBEC_PEND_W-1:0] pend_d;
	reg [`CSBEC_PEND_W-1:0] add;
	integer i;

	// queue events, saturating at 15 pending, so simultaneous sources each get a pulse
	always @*
	begin
		add = {`CSBEC_PEND_W{1'b0}};
		for (i = 0; i < NSRC; i = i + 1)
			add = add + {{(`CSBEC_PEND_W-1){1'b0}}, event_in[i]};
		pend_d = pend_q;
		if (sys_en && (pend_q != {`CSBEC_PEND_W{1'b0}}))
			pend_d = pend_q - 4'h1;
		if (pend_d <= ({`CSBEC_PEND_W{1'b1}} - add))
			pend_d = pend_d + add;
		else
			pend_d = {`CSBEC_PEND_W{1'b1}};
	end

	// low for one system period per queued event
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			pend_q <= 4'h0;
			pulse_n_q <= 1'b1;
		end
		else
		begin
			pend_q <= pend_d;
			if (sys_en)
				pulse_n_q <= (pend_q == 4'h0);
		end
	end
endmodule // csbec_pulse
`default_nettype wire

// File: verification/csbec_top_props.sv
/*
 checker for csbec_top: timing and coding relations at the ports.
 assumes one clock and sync reset; bound into every csbec_top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csbec_regs.vh"
module csbec_props (
	input wire ref_clk,
	input wire reset,
	input wire l2_correction_enable,
	input wire l2_rd_valid,
	input wire [127:0] l2_rd_data,
	input wire [9:0] l2_data_check_bits_in,
	input wire l2_reread_req_q,
	input wire l2_out_valid_q,
	input wire [127:0] l2_wr_data,
	input wire [9:0] l2_data_check_bits_out,
	input wire [25:0] l2_tag_wr,
	input wire [6:0] l2_label_check_bits_out,
	input wire bus_drive_oe_q,
	input wire bus_valid_strobe_n_o_q,
	input wire [11:0] command_bus_o_q,
	input wire command_parity_o_q,
	input wire [63:0] addr_data_bus_o_q,
	input wire [7:0] addr_data_check_bits_o_q,
	input wire cache_err_exc_q,
	input wire data_fault_flag_q,
	input wire label_fault_flag_q,
	input wire cmd_parity_flag_q,
	input wire addr_phase_flag_q,
	input wire perf_count0_event_q,
	input wire corrected_error_pulse_n,
	input wire fatal_error_pulse_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// raw beat in noncorrection mode, split by parity result
	wire raw_rd = l2_rd_valid && !l2_correction_enable && !l2_reread_req_q;
	wire par_bad = ^{l2_rd_data, l2_data_check_bits_in[9]};
	a_raw_path: assert property (raw_rd && !par_bad |=> l2_out_valid_q)
		else $error("good raw beat not output next cycle");
	a_reread_start: assert property (raw_rd && par_bad |=> l2_reread_req_q && !l2_out_valid_q)
		else $error("parity error did not start re-read");
	a_cor_latency: assert property (l2_rd_valid && l2_correction_enable |-> ##3 l2_out_valid_q)
		else $error("corrector path latency wrong");
	a_cor_pulse: assert property ($fell(corrected_error_pulse_n) |-> (!corrected_error_pulse_n)[*4])
		else $error("corrected pulse shorter than a system period");
	a_fatal_pulse: assert property ($fell(fatal_error_pulse_n) |-> (!fatal_error_pulse_n)[*4])
		else $error("fatal pulse shorter than a system period");
	a_perf_pulse: assert property (perf_count0_event_q |-> ##[0:70] !corrected_error_pulse_n)
		else $error("counted correction without corrected pulse");
	a_exc_flag: assert property ($rose(cache_err_exc_q) |->
		data_fault_flag_q || label_fault_flag_q || cmd_parity_flag_q || addr_phase_flag_q)
		else $error("exception without fault flag");
	a_tx_parity: assert property (!bus_valid_strobe_n_o_q |->
		bus_drive_oe_q && ^{command_bus_o_q, command_parity_o_q})
		else $error("driven command without odd parity");
	a_tx_ecc: assert property (!bus_valid_strobe_n_o_q |->
		^addr_data_check_bits_o_q == ^addr_data_bus_o_q)
		else $error("driven check bits inconsistent with data");
	a_data_ecc: assert property (^l2_data_check_bits_out[8:0] == ^l2_wr_data
		&& l2_data_check_bits_out[9] == ^l2_wr_data)
		else $error("data write check bits wrong");
	a_tag_ecc: assert property (^l2_label_check_bits_out == ^l2_tag_wr)
		else $error("tag write check bits wrong");
	// main scenarios reached
	c_reread: cover property ($rose(l2_reread_req_q));
	c_exc: cover property ($rose(cache_err_exc_q));
	c_tx: cover property (!bus_valid_strobe_n_o_q);
endmodule // csbec_props
bind csbec_top csbec_props u_csbec_props (.*);
`default_nettype wire

// File: verification/csbec_agent.sv
/*
 external agent on the system bus: drives one slave cycle per call.
 assumes the checker evaluates pins once per 4-cycle system period.
*/
`timescale 1ns/1ps
`default_nettype none
module csbec_agent #(
	parameter HOLD = 4
) (
	input wire ref_clk,
	output var logic bus_valid_strobe_n,
	output var logic [11:0] command_bus,
	output var logic command_parity,
	output var logic [63:0] addr_data_bus,
	output var logic [7:0] addr_data_check_bits
);
	// idle bus at time zero
	initial
	begin
		bus_valid_strobe_n = 1'b1;
		command_bus = 12'h0;
		command_parity = 1'b1;
		addr_data_bus = 64'h0;
		addr_data_check_bits = 8'h0;
	end
	// one valid cycle held a whole system period, then released
	task automatic send(input logic [11:0] cmd, input logic [63:0] ad,
		input logic [7:0] chk, input logic bad_par);
		@(negedge ref_clk);
		bus_valid_strobe_n = 1'b0;
		command_bus = cmd;
		// odd parity unless told to break it
		command_parity = ~^cmd ^ bad_par;
		// check bits travel with the data
		addr_data_bus = ad;
		addr_data_check_bits = chk;
		repeat (HOLD) @(negedge ref_clk);
		// released lines flip so no stale value is seen
		bus_valid_strobe_n = 1'b1;
		command_bus = ~cmd;
		addr_data_bus = ~ad;
		addr_data_check_bits = ~chk;
	endtask
endmodule // csbec_agent
`default_nettype wire

// File: verification/test_cache_sysbus_error_check.sv
/*
 self-checking bench for csbec_top with the bus agent.
 assumes zero data has all-zero check bits, so errors are bit flips.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module test_cache_sysbus_error_check;
	logic ref_clk = 1'b0, reset = 1'b1, l2_correction_enable = 1'b0, l2_rd_valid = 1'b0;
	logic [127:0] l2_rd_data = 128'h0, l2_wr_data = 128'h0;
	logic [9:0] l2_data_check_bits_in = 10'h0;
	logic [15:0] l2_rd_index = 16'h0, l2_tag_index = 16'h0;
	logic l2_tag_rd_valid = 1'b0, master_state = 1'b0, mst_valid = 1'b0, cache_fault_clear = 1'b0;
	logic [25:0] l2_tag_rd = 26'h0, l2_tag_wr = 26'h0;
	logic [6:0] l2_label_check_bits_in = 7'h0;
	logic [11:0] mst_cmd = 12'h0;
	logic [63:0] mst_ad = 64'h0;
	logic own_read_data = 1'b0;
	wire l2_reread_req_q, l2_out_valid_q, bus_drive_oe_q, bus_valid_strobe_n_o_q;
	wire [127:0] l2_out_data_q;
	wire [9:0] l2_data_check_bits_out;
	wire [25:0] l2_tag_fixed;
	wire [6:0] l2_label_check_bits_out;
	wire [11:0] command_bus_o_q, rx_cmd_q, command_bus;
	wire command_parity_o_q, rx_valid_q, rx_unc_q, cache_err_exc_q, command_parity;
	wire [63:0] addr_data_bus_o_q, rx_ad_q, addr_data_bus;
	wire [7:0] addr_data_check_bits_o_q, addr_data_check_bits;
	wire data_fault_flag_q, label_fault_flag_q, cmd_parity_flag_q, addr_phase_flag_q;
	wire [15:0] l2_set_position_field_q;
	wire perf_count0_event_q, corrected_error_pulse_n, fatal_error_pulse_n, bus_valid_strobe_n;
	int miscompares = 0, check_count = 0;
	int n_cor, n_unc, n_perf, n_exc, n_out, n_rx;
	logic [127:0] last_out;
	logic [63:0] last_rx;
	logic [11:0] last_cmd;
	logic pc = 1'b1, pf = 1'b1, pr = 1'b0, su = 1'b0;
	csbec_top u_csbec_top (.*);
	csbec_agent u_csbec_agent (.*);
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	// event counters seen at the ports, sampled where outputs are settled
	always @(negedge ref_clk)
	begin
		n_cor += pc & ~corrected_error_pulse_n;
		n_unc += pf & ~fatal_error_pulse_n;
		pc = corrected_error_pulse_n;
		pf = fatal_error_pulse_n;
		n_perf += perf_count0_event_q;
		n_exc += cache_err_exc_q;
		n_out += l2_out_valid_q;
		n_rx += ~pr & rx_valid_q;
		pr = rx_valid_q;
		su |= rx_unc_q;
		if (l2_out_valid_q) last_out = l2_out_data_q;
		if (rx_valid_q) last_rx = rx_ad_q;
		if (rx_valid_q) last_cmd = rx_cmd_q;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic clr();
		@(negedge ref_clk);
		{n_cor, n_unc, n_perf, n_exc, n_out, n_rx} = '0;
		su = 1'b0;
	endtask
	// one read beat; caller drops valid
	task automatic rd(input logic en, input logic [127:0] d, input logic [15:0] i);
		l2_correction_enable = en;
		l2_rd_valid = 1'b1;
		l2_rd_data = d;
		l2_rd_index = i;
		@(negedge ref_clk);
	endtask
	task automatic flags_clear();
		cache_fault_clear = 1'b1;
		idle(1);
		cache_fault_clear = 1'b0;
		idle(1);
	endtask
	task automatic t_corr_mode();
		clr();
		rd(1'b1, 128'h20, 16'h0);
		l2_rd_valid = 1'b0;
		idle(30);
		`CHK(last_out, 128'h0)
		`CHK(n_out, 1)
		`CHK(n_cor, 1)
		`CHK(n_perf, 1)
		`CHK(n_exc, 0)
		$display("correction mode beat done");
	endtask
	task automatic t_reread();
		clr();
		rd(1'b0, 128'h0, 16'h0);
		rd(1'b0, 128'h8, 16'h0);
		l2_rd_valid = 1'b0;
		idle(1);
		`CHK(l2_reread_req_q, 1'b1)
		for (int k = 0; k < 8; k++) rd(1'b0, (k == 0) ? 128'h10 : 128'h0, 16'h0);
		l2_rd_valid = 1'b0;
		idle(30);
		`CHK(l2_reread_req_q, 1'b0)
		`CHK(n_out, 9)
		`CHK(last_out, 128'h0)
		`CHK(n_cor, 1)
		`CHK(n_perf, 1)
		$display("parity re-read done");
	endtask
	task automatic t_data_unc();
		clr();
		rd(1'b1, 128'h3, 16'h1234);
		l2_rd_valid = 1'b0;
		idle(30);
		`CHK(n_exc, 1)
		`CHK(data_fault_flag_q, 1'b1)
		`CHK(l2_set_position_field_q, 16'h1234)
		`CHK(n_cor, 0)
		flags_clear();
		`CHK(data_fault_flag_q, 1'b0)
		$display("data uncorrectable done");
	endtask
	task automatic t_tag();
		clr();
		l2_tag_rd_valid = 1'b1;
		l2_tag_rd = 26'h2000000;
		#1 `CHK(l2_tag_fixed, 26'h0)
		@(negedge ref_clk);
		l2_tag_rd = 26'h3;
		l2_tag_index = 16'h00A5;
		@(negedge ref_clk);
		l2_tag_rd_valid = 1'b0;
		idle(30);
		`CHK(n_cor, 1)
		`CHK(n_unc, 1)
		`CHK(n_exc, 1)
		`CHK(label_fault_flag_q, 1'b1)
		`CHK(l2_set_position_field_q, 16'h00A5)
		flags_clear();
		$display("tag checks done");
	endtask
	task automatic t_write();
		idle(1);
		`CHK(l2_data_check_bits_out, 10'h000)
		`CHK(l2_label_check_bits_out, 7'h00)
		l2_wr_data = 128'h1;
		l2_tag_wr = 26'h1;
		idle(1);
		`CHK(l2_data_check_bits_out, 10'h207)
		`CHK(l2_label_check_bits_out, 7'h07)
		l2_wr_data = 128'h3;
		idle(1);
		`CHK(l2_data_check_bits_out, 10'h00C)
		$display("write check bits done");
	endtask
	task automatic t_master();
		master_state = 1'b1;
		mst_valid = 1'b1;
		mst_cmd = 12'h0A5;
		mst_ad = 64'h1;
		for (int k = 0; k < 20 && bus_valid_strobe_n_o_q !== 1'b0; k++) @(negedge ref_clk);
		`CHK(bus_valid_strobe_n_o_q, 1'b0)
		`CHK(command_bus_o_q, 12'h0A5)
		`CHK(command_parity_o_q, 1'b1)
		`CHK(addr_data_bus_o_q, 64'h1)
		`CHK(addr_data_check_bits_o_q, 8'h07)
		`CHK(bus_drive_oe_q, 1'b1)
		mst_valid = 1'b0;
		master_state = 1'b0;
		idle(10);
		`CHK(bus_valid_strobe_n_o_q, 1'b1)
		`CHK(bus_drive_oe_q, 1'b0)
		$display("master drive done");
	endtask
	task automatic t_slave();
		clr();
		u_csbec_agent.send(12'h802, 64'h0, 8'h01, 1'b0);
		idle(10);
		`CHK(n_rx, 1)
		`CHK(n_cor, 0)
		u_csbec_agent.send(12'h801, 64'h80, 8'h0, 1'b0);
		idle(20);
		`CHK(n_rx, 2)
		`CHK(last_rx, 64'h0)
		`CHK(n_cor, 1)
		u_csbec_agent.send(12'h003, 64'h0, 8'h0, 1'b1);
		idle(20);
		`CHK(n_rx, 2)
		`CHK(cmd_parity_flag_q, 1'b1)
		`CHK(n_unc, 1)
		u_csbec_agent.send(12'h801, 64'h3, 8'h0, 1'b0);
		idle(20);
		`CHK(n_rx, 2)
		`CHK(addr_phase_flag_q, 1'b1)
		`CHK(n_unc, 2)
		`CHK(n_exc, 2)
		own_read_data = 1'b1;
		u_csbec_agent.send(12'h001, 64'h80, 8'h0, 1'b0);
		idle(20);
		`CHK(last_rx, 64'h0)
		`CHK(last_cmd, 12'h001)
		`CHK(n_cor, 2)
		u_csbec_agent.send(12'h001, 64'h3, 8'h0, 1'b0);
		idle(20);
		own_read_data = 1'b0;
		`CHK(n_rx, 4)
		`CHK(su, 1'b1)
		`CHK(n_unc, 2)
		flags_clear();
		$display("slave checks done");
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(negedge ref_clk);
		reset = 1'b0;
		idle(3);
		t_corr_mode();
		t_reread();
		t_data_unc();
		t_tag();
		t_write();
		t_master();
		t_slave();
		end_of_test();
	end
	// watchdog
	initial
	begin
		#20000;
		miscompares++;
		end_of_test();
	end
endmodule // test_cache_sysbus_error_check
`default_nettype wire
